// file: pkg/host_port_regs.svh
/*
 Constants of the host register port: bus widths, the two locations of the
 production test flag, its bit position and the number of interrupt sources.
 Assumes inclusion by its bare name from any file that needs the figures.
*/
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

`define HP_ADDR_W          10
`define HP_DATA_W          8
`define HP_TEST_ADDR_LOW   10'h00B
`define HP_TEST_ADDR_HIGH  10'h20B
`define HP_TEST_FLAG_BIT   0
`define HP_TEST_FLAG_RST   1'h1
`define HP_NUM_SRC         8
`define HP_ADDR_RST        10'h000
`define HP_DATA_RST        8'h00

`endif

// file: pkg/host_port_pkg.sv
/*
 Types shared by the host register port modules.
 Assumes host_port_regs.svh is reachable on the include path.
*/
`include "host_port_regs.svh"

package host_port_pkg;

   typedef logic [`HP_ADDR_W-1:0] addr_t;
   typedef logic [`HP_DATA_W-1:0] data_t;

   typedef enum logic [1:0] {
      ACC_IDLE  = 2'h0,
      ACC_READ  = 2'h1,
      ACC_WRITE = 2'h2
   } access_state_t;

endpackage : host_port_pkg

// file: pkg/pin_sample_if.sv
/*
 Carrier between the top of the host port and its pin sampler: sampled
 pin levels in, held address, held write data and the write commit event out.
 Assumes one clock domain; all signals change on the rising edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none

interface pin_sample_if;
   logic                 select_n;
   logic                 write_n;
   logic                 ale;
   host_port_pkg::addr_t addr_pin;
   host_port_pkg::data_t data_pin;
   host_port_pkg::addr_t addr_held;
   host_port_pkg::data_t data_held;
   logic                 write_rise;

   modport top (output select_n, write_n, ale, addr_pin, data_pin,
                input  addr_held, data_held, write_rise);
   modport sampler (input  select_n, write_n, ale, addr_pin, data_pin,
                    output addr_held, data_held, write_rise);
endinterface : pin_sample_if

`default_nettype wire

// file: rtl/strobe_sampler.sv
/*
 Address latch and write strobe edge finder of the host port.
 Assumes pins already synchronous to clk and reset by the top.
*/
`timescale 1ns/1ns
`default_nettype none
`include "host_port_regs.svh"

module strobe_sampler (
   // Clock and reset
   input  wire logic    clk,
   input  wire logic    resetn,
   // Pin side
   pin_sample_if.sampler pins
);

   logic write_prev_n;

   // Transparent while latch enable high, frozen while low
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pins.addr_held <= `HP_ADDR_RST;
      end else if (pins.ale) begin
         pins.addr_held <= pins.addr_pin; // R6
      end
   end

   // Data taken while the strobe is still low, so the rising edge
   // uses the value the host set up, not one already moving
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pins.data_held <= `HP_DATA_RST;
      end else if (!pins.write_n) begin
         pins.data_held <= pins.data_pin;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         write_prev_n <= 1'h1;
      end else begin
         write_prev_n <= pins.write_n;
      end
   end

   assign pins.write_rise = !write_prev_n && pins.write_n && !pins.select_n; // R5

   a_addr_hold: assert property (@(posedge clk) disable iff (!resetn) // R6
      !pins.ale |=> pins.addr_held == $past(pins.addr_held))
      else $error("address moved while latch closed");

   a_addr_pass: assert property (@(posedge clk) disable iff (!resetn) // R6
      pins.ale |=> pins.addr_held == $past(pins.addr_pin))
      else $error("address not passed while latch open");

endmodule : strobe_sampler

`default_nettype wire

// file: rtl/quad_e1_framer_host_port.sv
/*
 Host register port of the quad framer: select, read and write strobes,
 latched 10-bit address, 8-bit two-way data bus, open-drain interrupt.
 Assumes all pins synchronous to clk; internal blocks answer reg_rdata
 combinationally from reg_addr and hold their own masked interrupt levels.
*/
`timescale 1ns/1ns
`default_nettype none
`include "host_port_regs.svh"

// What this block does
// [R1] Host keeps select low through each access; strobes ignored while select high.
// [R2] Select high clears the production test flag, read at two locations.
// [R3] Host reads by pulsing read strobe low with select low, address valid.
// [R4] Addressed register drives data bus while read strobe and select are low.
// [R5] Write data captured on write strobe rising edge while select low.
// [R6] Address latch transparent while latch enable high, holds while low.
// [R7] Ten address lines decode to one internal register per access.
// [R8] Reset input low resets the whole port at once, no clock needed.
// [R9] Interrupt pin pulled low when any unmasked internal source is active.
// [R10] Interrupt pin held low until every active unmasked source is acknowledged.
// [R11] Data bus left undriven except during a selected read.

module quad_e1_framer_host_port (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  resetn,
   // Host strobes and address
   input  wire logic                  host_select_n,
   input  wire logic                  read_strobe_n,
   input  wire logic                  write_strobe_n,
   input  wire logic                  addr_latch_en,
   input  wire host_port_pkg::addr_t  addr,
   // Two-way data bus
   input  wire host_port_pkg::data_t  data_in,
   output var  host_port_pkg::data_t  data_out,
   output var  logic                  data_oe,
   // Open-drain interrupt
   output var  logic                  irq_out_n,
   output var  logic                  irq_oe,
   // Internal register access
   output var  host_port_pkg::addr_t  reg_addr,
   output var  host_port_pkg::data_t  reg_wdata,
   output var  logic                  reg_wr,
   output var  logic                  reg_rd,
   input  wire host_port_pkg::data_t  reg_rdata,
   // Internal interrupt sources and test mode
   input  wire logic [`HP_NUM_SRC-1:0] src_irq,
   output var  logic                  production_test_flag
);

   host_port_pkg::access_state_t state;
   host_port_pkg::access_state_t next_state;
   host_port_pkg::data_t         next_rdata;
   logic                         read_sel;
   logic                         write_sel;

   pin_sample_if pins ();

   assign pins.select_n = host_select_n;
   assign pins.write_n  = write_strobe_n;
   assign pins.ale      = addr_latch_en;
   assign pins.addr_pin = addr;
   assign pins.data_pin = data_in;

   strobe_sampler u_sampler (
      .clk    (clk),
      .resetn (resetn),
      .pins   (pins)
   );

   // Both test flag locations decode alike
   function automatic logic is_test_addr(input host_port_pkg::addr_t a);
      is_test_addr = (a == `HP_TEST_ADDR_LOW) || (a == `HP_TEST_ADDR_HIGH);
   endfunction : is_test_addr

   // Strobes only count with select low
   assign read_sel  = !host_select_n && !read_strobe_n;  // R1 R3
   assign write_sel = !host_select_n && !write_strobe_n; // R1

   // Read wins if the host asserts both strobes while idle
   always_comb begin
      next_state = state;
      case (state)
         host_port_pkg::ACC_IDLE: begin
            if (read_sel) begin
               next_state = host_port_pkg::ACC_READ;
            end else if (write_sel) begin
               next_state = host_port_pkg::ACC_WRITE;
            end
         end
         host_port_pkg::ACC_READ: begin
            if (!read_sel) begin
               next_state = host_port_pkg::ACC_IDLE;
            end
         end
         host_port_pkg::ACC_WRITE: begin
            // Deselect mid-write abandons the access
            if (host_select_n || write_strobe_n) begin
               next_state = host_port_pkg::ACC_IDLE; // R1
            end
         end
         default: begin
            next_state = host_port_pkg::ACC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= host_port_pkg::ACC_IDLE; // R8
      end else begin
         state <= next_state;
      end
   end

   // Address follows the latch every cycle, so internal read data is ready
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_addr <= `HP_ADDR_RST;
      end else begin
         reg_addr <= pins.addr_held; // R7
      end
   end

   // Write commit pulse with the data set up under the low strobe
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_wr    <= 1'h0;
         reg_wdata <= `HP_DATA_RST;
      end else begin
         reg_wr <= (state == host_port_pkg::ACC_WRITE) && pins.write_rise; // R5
         if ((state == host_port_pkg::ACC_WRITE) && pins.write_rise) begin
            reg_wdata <= pins.data_held; // R5
         end
      end
   end

   // One pulse per read, for blocks that clear status on read
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rd <= 1'h0;
      end else begin
         reg_rd <= (state == host_port_pkg::ACC_IDLE) && read_sel;
      end
   end

   always_comb begin
      next_rdata = reg_rdata;
      if (is_test_addr(reg_addr)) begin
         next_rdata[`HP_TEST_FLAG_BIT] = production_test_flag; // R2 R7
      end
   end

   // Driver on only while selected and read-strobed; one clock of lag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         data_oe  <= 1'h0;
         data_out <= `HP_DATA_RST;
      end else begin
         data_oe <= read_sel; // R4 R11
         if (read_sel) begin
            data_out <= next_rdata; // R4
         end
      end
   end

   // Set by reset, cleared by the first high level seen on select
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         production_test_flag <= `HP_TEST_FLAG_RST;
      end else if (host_select_n) begin
         production_test_flag <= 1'h0; // R2
      end
   end

   // Sources hold their level until acknowledged, so a plain OR keeps
   // the pin low until the last one is served
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq_oe    <= 1'h0;
         irq_out_n <= 1'h0;
      end else begin
         irq_oe    <= |src_irq; // R9 R10
         irq_out_n <= 1'h0;
      end
   end

   a_read_drive: assert property (@(posedge clk) disable iff (!resetn) // R4
      read_sel |=> data_oe && data_out == $past(next_rdata))
      else $error("selected read did not drive the bus");

   a_bus_release: assert property (@(posedge clk) disable iff (!resetn) // R11
      !read_sel |=> !data_oe)
      else $error("data bus driven outside a read");

   a_write_commit: assert property (@(posedge clk) disable iff (!resetn) // R5
      (state == host_port_pkg::ACC_WRITE) && !host_select_n && !write_strobe_n
      ##1 !host_select_n && write_strobe_n
      |=> reg_wr && reg_wdata == $past(pins.data_held))
      else $error("write edge not committed");

   a_no_stray_write: assert property (@(posedge clk) disable iff (!resetn) // R1
      $past(host_select_n) |-> !reg_wr)
      else $error("write committed while deselected");

   a_addr_follow: assert property (@(posedge clk) disable iff (!resetn) // R7
      reg_wr |-> reg_addr == $past(pins.addr_held))
      else $error("write address not the latched one");

   a_flag_clear: assert property (@(posedge clk) disable iff (!resetn) // R2
      host_select_n |=> !production_test_flag [*2])
      else $error("test flag not cleared by select high");

   a_reset_values: assert property (@(posedge clk) disable iff (!resetn) // R8
      $rose(resetn) |-> !data_oe && !reg_wr && !irq_oe && production_test_flag)
      else $error("outputs not at reset values");

   a_irq_assert: assert property (@(posedge clk) disable iff (!resetn) // R9
      (|src_irq) |=> irq_oe && !irq_out_n)
      else $error("interrupt not raised for active source");

   a_irq_release: assert property (@(posedge clk) disable iff (!resetn) // R10
      (|src_irq) ##1 !(|src_irq) |=> !irq_oe)
      else $error("interrupt not released after acknowledge");

endmodule : quad_e1_framer_host_port

`default_nettype wire

// file: testbench/host_model.sv
/*
 Host processor model: whole byte reads and writes on the host port pins.
 Assumes one access at a time, started after reset by the testbench.
*/
`timescale 1ns/1ns
`default_nettype none

module host_model (
   // Clock
   input  wire logic                 clk,
   // Host pins
   output var  logic                 host_select_n,
   output var  logic                 read_strobe_n,
   output var  logic                 write_strobe_n,
   output var  logic                 addr_latch_en,
   output var  host_port_pkg::addr_t addr,
   output var  host_port_pkg::data_t data_in,
   input  wire host_port_pkg::data_t data_out,
   input  wire logic                 data_oe
);
   host_port_pkg::data_t wd;
   logic                 drv;
   logic                 keep_sel;

   // Released bus shows the inverse, never a stale copy
   assign data_in = data_oe ? data_out : (drv ? wd : ~wd);

   initial begin
      host_select_n  = 1'h0;
      read_strobe_n  = 1'h1;
      write_strobe_n = 1'h1;
      addr_latch_en  = 1'h1;
      addr           = 10'h000;
      wd             = 8'h00;
      drv            = 1'h0;
      keep_sel       = 1'h1;
   end

   // Mode 0 normal, 1 select rises before strobe, 2 select high throughout
   task automatic access(input logic rd, input host_port_pkg::addr_t a,
                         input host_port_pkg::data_t wdat, input int mode,
                         output host_port_pkg::data_t q);
      @(posedge clk);
      host_select_n <= (mode == 2);
      addr_latch_en <= 1'h1;
      addr          <= a;
      wd            <= wdat;
      drv           <= !rd;
      repeat (2) @(posedge clk);
      addr_latch_en <= 1'h0;
      @(posedge clk);
      // Multiplexed bus reuses the address lines
      addr <= ~a;
      if (rd) read_strobe_n <= 1'h0;
      else write_strobe_n <= 1'h0;
      repeat (3) @(posedge clk);
      #1 q = data_out;
      @(posedge clk);
      if (mode == 1) host_select_n <= 1'h1;
      else begin
         read_strobe_n  <= 1'h1;
         write_strobe_n <= 1'h1;
      end
      @(posedge clk);
      read_strobe_n  <= 1'h1;
      write_strobe_n <= 1'h1;
      drv            <= 1'h0;
      host_select_n  <= !keep_sel;
      @(posedge clk);
   endtask : access
endmodule : host_model

`default_nettype wire

// file: testbench/testbench.sv
/*
 Self-checking bench of the host register port.
 Assumes host_model as the host and a stand-in register file on reg_rdata.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
   logic                 clk;
   logic                 resetn;
   logic                 sel_n, rd_n, wr_n, ale, data_oe, irq_out_n, irq_oe;
   logic                 reg_wr, reg_rd, flag;
   host_port_pkg::addr_t addr, reg_addr, wr_addr;
   host_port_pkg::data_t data_in, data_out, reg_wdata, reg_rdata, wr_data, q;
   logic [7:0]           src_irq;
   int                   n_errors = 0;
   int                   total_checks = 0;
   int                   n_wr = 0;
   int                   n_rd = 0;

   assign reg_rdata = reg_addr[7:0] ^ 8'h5A;

   host_model i_host_model (.clk(clk), .host_select_n(sel_n), .read_strobe_n(rd_n),
      .write_strobe_n(wr_n), .addr_latch_en(ale), .addr(addr), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe));

   quad_e1_framer_host_port i_quad_e1_framer_host_port (.clk(clk), .resetn(resetn),
      .host_select_n(sel_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
      .addr_latch_en(ale), .addr(addr), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .irq_out_n(irq_out_n), .irq_oe(irq_oe), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .src_irq(src_irq), .production_test_flag(flag));

   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      if (reg_wr === 1'h1) begin
         n_wr++;
         wr_addr = reg_addr;
         wr_data = reg_wdata;
      end
      if (reg_rd === 1'h1) n_rd++;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      $display("errors %0d checks %0d", n_errors, total_checks);
      if (n_errors == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : report_and_stop

   task automatic t_flag;
      // Select goes high only after this first read, so the flag is still set
      i_host_model.keep_sel = 1'h0;
      i_host_model.access(1'h1, 10'h00B, 8'h00, 0, q);
      check("flag set", 16'(q), 16'(8'h51));
      i_host_model.access(1'h1, 10'h20B, 8'h00, 0, q);
      check("flag clear", 16'(q), 16'(8'h50));
   endtask : t_flag

   task automatic t_write;
      i_host_model.access(1'h0, 10'h155, 8'hA5, 0, q);
      i_host_model.access(1'h0, 10'h2AA, 8'h3C, 0, q);
      // Counting process sees the last pulse on this same edge; step past it
      @(negedge clk);
      check("write count", 16'(n_wr), 16'h0002);
      check("write addr", 16'(wr_addr), 16'h02AA);
      check("write data", 16'(wr_data), 16'h003C);
      i_host_model.access(1'h0, 10'h101, 8'h11, 1, q);
      i_host_model.access(1'h0, 10'h102, 8'h22, 2, q);
      @(negedge clk);
      check("refused writes", 16'(n_wr), 16'h0002);
   endtask : t_write

   task automatic t_read;
      i_host_model.access(1'h1, 10'h0C3, 8'h00, 0, q);
      check("read data", 16'(q), 16'h0099);
      check("read pulses", 16'(n_rd), 16'h0003);
      check("bus released", 16'(data_oe), 16'h0000);
   endtask : t_read

   task automatic t_irq;
      @(posedge clk) src_irq <= 8'h20;
      repeat (2) @(posedge clk);
      #1 check("irq on", 16'({irq_oe, irq_out_n}), 16'h0002);
      @(posedge clk) src_irq <= 8'h21;
      @(posedge clk) src_irq <= 8'h01;
      repeat (2) @(posedge clk);
      #1 check("irq held", 16'(irq_oe), 16'h0001);
      @(posedge clk) src_irq <= 8'h00;
      repeat (2) @(posedge clk);
      #1 check("irq off", 16'(irq_oe), 16'h0000);
   endtask : t_irq

   task automatic t_async;
      @(posedge clk) src_irq <= 8'hFF;
      repeat (3) @(posedge clk);
      #10 resetn = 1'h0;
      #5 check("async reset", 16'({irq_oe, flag, reg_wr}), 16'h0002);
      @(posedge clk) src_irq <= 8'h00;
      @(posedge clk) resetn <= 1'h1;
   endtask : t_async

   initial begin
      resetn  = 1'h0;
      src_irq = 8'h00;
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      #1 check("reset outputs", 16'({data_oe, irq_oe, flag, reg_wr}), 16'h0002);
      t_flag();
      t_write();
      t_read();
      t_irq();
      t_async();
      report_and_stop();
   end

   // Whole run needs about 100 cycles
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      report_and_stop();
   end
endmodule : testbench

`default_nettype wire
